// [pbc_button_model.sv]
// switch model: a contact that closes, chatters and opens
`timescale 1ns/1ps
module pbc_button_model #(
    parameter bit PB_ACTIVE_HIGH = 1'b0
) (
    input wire logic clk,
    output logic pin
);
    // open contact rests at its pull level, the inverse of closed
    initial pin = !PB_ACTIVE_HIGH;
    // close for n cycles, then open again
    task automatic press(input int n);
        @(posedge clk);
        pin <= PB_ACTIVE_HIGH;
        repeat (n) @(posedge clk);
        pin <= !PB_ACTIVE_HIGH;
    endtask : press
    // chatter: k short closures, each below the debounce span
    task automatic chatter(input int k, input int n);
        repeat (k) begin
            press(n);
            repeat (n / 2) @(posedge clk);
        end
    endtask : chatter
endmodule : pbc_button_model

// [pbc_ctrl.sv]
// pushbutton on/off controller: debounce, latch, interrupt pulse
`timescale 1ns/1ps
// Operation
// R01: The latched output turns on once a closure outlasts the debounce time.
// R02: Each valid closure gives one interrupt pulse of the chosen length.
// R03: A closure held past the shutdown time gives a longer interrupt pulse.
// R04: The shutdown time is one of two fixed choices.
// R05: One variant turns the output off after shutdown, the other keeps it on.
// R06: The force-off input turns the output off at once.
// R07: The button is read active low or active high as the variant fixes.
// R08: Closures shorter than debounce change nothing and restart the timer.
module pbc_ctrl #(
    parameter bit DB_OPT = 1'b0,
    parameter logic [1:0] INT_OPT = 2'h0,
    parameter bit SD_OPT = 1'b0,
    parameter bit RELEASE_ON_SD = 1'b1,
    parameter bit PB_ACTIVE_HIGH = 1'b0,
    parameter logic [31:0] DB_SHORT_CYC = pbc_pkg::DB_SHORT_CYC,
    parameter logic [31:0] DB_LONG_CYC = pbc_pkg::DB_LONG_CYC,
    parameter logic [31:0] INT_8_CYC = pbc_pkg::INT_8_CYC,
    parameter logic [31:0] INT_32_CYC = pbc_pkg::INT_32_CYC,
    parameter logic [31:0] INT_64_CYC = pbc_pkg::INT_64_CYC,
    parameter logic [31:0] INT_128_CYC = pbc_pkg::INT_128_CYC,
    parameter logic [31:0] SD_SHORT_CYC = pbc_pkg::SD_SHORT_CYC,
    parameter logic [31:0] SD_LONG_CYC = pbc_pkg::SD_LONG_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pushbutton_input,
    input wire logic force_off_input,
    output logic latched_out,
    output logic int_out,
    output logic irq,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    // ==========================================================
    // types and variant timing
    // ==========================================================
    typedef enum logic [3:0] {
        PBC_IDLE = 4'b0001,
        PBC_DEBOUNCE = 4'b0010,
        PBC_HELD = 4'b0100,
        PBC_WAIT_REL = 4'b1000
    } pbc_state_e;

    // timing fixed by the variant parameters
    localparam logic [31:0] DB_CYC = DB_OPT ? DB_LONG_CYC : DB_SHORT_CYC;
    localparam logic [31:0] SD_CYC = SD_OPT ? SD_LONG_CYC : SD_SHORT_CYC;
    // see R04
    localparam logic [31:0] INT_CYC =
        (INT_OPT == 2'h0) ? INT_8_CYC :
        (INT_OPT == 2'h1) ? INT_32_CYC :
        (INT_OPT == 2'h2) ? INT_64_CYC : INT_128_CYC;
    // see R02
    localparam logic [31:0] LONG_INT_CYC =
        32'(INT_CYC * pbc_pkg::LONG_INT_MULT);
    // see R03

    // register decode, used for reads and writes alike
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ==========================================================
    // input synchronisers
    // ==========================================================
    logic pb_meta_q;
    logic pb_sync_q;
    logic clr_meta_q;
    logic clr_sync_q;
    logic pressed;

    // both pins are asynchronous to clk; two flops each
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            // reset to the open level, else a false closure follows reset
            pb_meta_q <= !PB_ACTIVE_HIGH;
            pb_sync_q <= !PB_ACTIVE_HIGH; // see R07
        end else begin
            pb_meta_q <= pushbutton_input;
            pb_sync_q <= pb_meta_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clr_meta_q <= 1'b0;
            clr_sync_q <= 1'b0;
        end else begin
            clr_meta_q <= force_off_input;
            clr_sync_q <= clr_meta_q;
        end
    end

    // closed level depends on the variant
    assign pressed = PB_ACTIVE_HIGH ? pb_sync_q : ~pb_sync_q; // see R07

    // ==========================================================
    // register bus decode
    // ==========================================================
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;

    assign wr_ctrl = reg_wr && hit(reg_addr, pbc_pkg::OFS_CTRL);
    assign wr_status = reg_wr && hit(reg_addr, pbc_pkg::OFS_STATUS);
    assign wr_mask = reg_wr && hit(reg_addr, pbc_pkg::OFS_MASK);

    // ==========================================================
    // closure timing state machine
    // ==========================================================
    pbc_state_e state_q;
    pbc_state_e state_d;
    logic [31:0] cnt_q;
    logic ev_closure;
    logic ev_shutdown;

    // one counter measures from the first closed sample onward
    always_comb begin
        state_d = state_q;
        ev_closure = 1'b0;
        ev_shutdown = 1'b0;
        case (state_q)
            PBC_IDLE: begin
                if (pressed) begin
                    state_d = PBC_DEBOUNCE;
                end
            end
            PBC_DEBOUNCE: begin
                if (!pressed) begin
                    state_d = PBC_IDLE; // see R08
                end else if (cnt_q >= DB_CYC - 32'h1) begin
                    state_d = PBC_HELD; // see R01
                    ev_closure = 1'b1;
                end
            end
            PBC_HELD: begin
                if (!pressed) begin
                    state_d = PBC_IDLE;
                end else if (cnt_q >= SD_CYC - 32'h1) begin
                    state_d = PBC_WAIT_REL; // see R04
                    ev_shutdown = 1'b1;
                end
            end
            PBC_WAIT_REL: begin
                // nothing more until the button is let go
                if (!pressed) begin
                    state_d = PBC_IDLE;
                end
            end
            default: begin
                state_d = PBC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= PBC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // counter restarts whenever the button is seen open
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 32'h0;
        end else if (state_d == PBC_IDLE) begin
            cnt_q <= 32'h0; // see R08
        end else if (state_q != PBC_IDLE && state_q != PBC_WAIT_REL) begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    // ==========================================================
    // control register
    // ==========================================================
    logic [1:0] ctrl_q;
    logic soft_off;
    logic soft_on;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= pbc_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata[1:0];
        end else begin
            ctrl_q[pbc_pkg::CTRL_SOFT_ON_BIT] <= 1'b0; // self-clearing
        end
    end

    assign soft_off = ctrl_q[pbc_pkg::CTRL_SOFT_OFF_BIT];
    assign soft_on = ctrl_q[pbc_pkg::CTRL_SOFT_ON_BIT];

    // ==========================================================
    // latched output
    // ==========================================================
    logic out_q;

    // off wins over on; soft_off holds the latch off while set
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_q <= 1'b0;
        end else if (clr_sync_q || soft_off) begin
            out_q <= 1'b0; // see R06
        end else if (ev_shutdown && RELEASE_ON_SD) begin
            out_q <= 1'b0; // see R05
        end else if (ev_closure || soft_on) begin
            out_q <= 1'b1; // see R01
        end
    end

    // the raw pin gates the latch so the off state needs no clock;
    // the synchronised copy then clears the flop itself
    assign latched_out = out_q & ~force_off_input; // see R06

    // ==========================================================
    // interrupt pulse timer
    // ==========================================================
    pbc_tmr_if tmr ();

    // normal pulse on a valid closure, longer one at shutdown
    assign tmr.start = ev_closure | ev_shutdown; // see R02
    assign tmr.len = ev_shutdown ? LONG_INT_CYC : INT_CYC; // see R03

    pbc_pulse_tmr u_tmr (
        .clk(clk),
        .arst_n(arst_n),
        .t(tmr.tmr)
    );

    // a flop keeps the pin clean of decode glitches, one cycle late
    logic int_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            int_q <= 1'b0;
        end else begin
            int_q <= tmr.busy; // see R02
        end
    end

    assign int_out = int_q;

    // ==========================================================
    // sticky status, mask and interrupt line
    // ==========================================================
    logic [pbc_pkg::EV_W-1:0] ev_now;
    logic [pbc_pkg::EV_W-1:0] status_q;
    logic [pbc_pkg::EV_W-1:0] mask_q;
    logic clr_seen_q;

    // force-off event is its rising edge, taken past the synchroniser
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clr_seen_q <= 1'b0;
        end else begin
            clr_seen_q <= clr_sync_q;
        end
    end

    always_comb begin
        ev_now = '0;
        ev_now[pbc_pkg::EV_CLOSURE_BIT] = ev_closure;
        ev_now[pbc_pkg::EV_SHUTDOWN_BIT] = ev_shutdown;
        ev_now[pbc_pkg::EV_FORCE_OFF_BIT] = clr_sync_q & ~clr_seen_q;
    end

    // write-one-to-clear, but a new event in the same cycle stays set
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= pbc_pkg::EV_RST;
        end else if (wr_status) begin
            status_q <= (status_q & ~reg_wdata[pbc_pkg::EV_W-1:0]) | ev_now;
        end else begin
            status_q <= status_q | ev_now;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= pbc_pkg::MASK_RST;
        end else if (wr_mask) begin
            mask_q <= reg_wdata[pbc_pkg::EV_W-1:0];
        end
    end

    // a set mask bit lets its status bit through
    assign irq = |(status_q & mask_q);

    // ==========================================================
    // read data
    // ==========================================================
    logic [31:0] rdata_q;
    logic [31:0] state_word;

    always_comb begin
        state_word = 32'h0;
        state_word[pbc_pkg::ST_OUT_BIT] = latched_out;
        state_word[pbc_pkg::ST_INT_BIT] = int_q;
        state_word[pbc_pkg::ST_PRESSED_BIT] = pressed;
        state_word[pbc_pkg::ST_FSM_LSB +: 4] = state_q;
    end

    // data only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h0;
        end else if (!reg_rd) begin
            rdata_q <= 32'h0;
        end else if (hit(reg_addr, pbc_pkg::OFS_CTRL)) begin
            rdata_q <= {30'h0, ctrl_q};
        end else if (hit(reg_addr, pbc_pkg::OFS_STATUS)) begin
            rdata_q <= {29'h0, status_q};
        end else if (hit(reg_addr, pbc_pkg::OFS_MASK)) begin
            rdata_q <= {29'h0, mask_q};
        end else if (hit(reg_addr, pbc_pkg::OFS_STATE)) begin
            rdata_q <= state_word;
        end else begin
            rdata_q <= 32'h0;
        end
    end

    assign reg_rdata = rdata_q;
endmodule : pbc_ctrl

// [pbc_ctrl_assertions.sv]
// port checker of the pushbutton on/off controller, with its bind
`timescale 1ns/1ps
module pbc_ctrl_chk #(
    parameter logic [31:0] DB_CYC = 32'h14,
    parameter logic [31:0] INT_CYC = 32'h5,
    parameter logic [31:0] SD_CYC = 32'h64,
    parameter bit PB_ACTIVE_HIGH = 1'b0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pushbutton_input,
    input wire logic force_off_input,
    input wire logic latched_out,
    input wire logic int_out,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    // ==========================================================
    // helper counters
    // ==========================================================
    logic [31:0] closed_q;
    logic [31:0] high_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // raw closure length; saturates so a long hold never wraps
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            closed_q <= 32'h0;
        end else if (pushbutton_input == PB_ACTIVE_HIGH) begin
            closed_q <= (closed_q == 32'hffff) ? closed_q : closed_q + 32'h1;
        end else begin
            closed_q <= 32'h0;
        end
    end
    // cycles the interrupt pulse has stood so far
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_q <= 32'h0;
        end else begin
            high_q <= int_out ? high_q + 32'h1 : 32'h0;
        end
    end
    // ==========================================================
    // properties
    // ==========================================================
    force_off_a: assert property (force_off_input |-> !latched_out)
        else $error("latched output on while forced off");
    on_late_a: assert property ($rose(latched_out) |-> closed_q >= DB_CYC)
        else $error("output on before debounce span");
    on_due_a: assert property ((closed_q == DB_CYC + 32'h4 &&
        !force_off_input) |-> latched_out)
        else $error("output not on after debounce span");
    int_follow_a: assert property ($rose(latched_out) |=> $rose(int_out))
        else $error("no pulse after output turned on");
    int_cause_a: assert property ($rose(int_out) |-> closed_q >= DB_CYC)
        else $error("pulse without a valid closure");
    int_len_a: assert property ($fell(int_out) |->
        (high_q == INT_CYC || high_q == INT_CYC * 32'h4))
        else $error("pulse length wrong");
    sd_off_a: assert property (closed_q == SD_CYC + 32'h4 |-> !latched_out)
        else $error("output still on after shutdown span");
    sd_pulse_a: assert property (closed_q == SD_CYC + 32'h4 |-> int_out)
        else $error("no long pulse at shutdown");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read answer cycle");
endmodule : pbc_ctrl_chk

bind pbc_ctrl pbc_ctrl_chk #(
    .DB_CYC(DB_OPT ? DB_LONG_CYC : DB_SHORT_CYC),
    .INT_CYC(INT_OPT == 2'h0 ? INT_8_CYC : INT_OPT == 2'h1 ? INT_32_CYC :
        INT_OPT == 2'h2 ? INT_64_CYC : INT_128_CYC),
    .SD_CYC(SD_OPT ? SD_LONG_CYC : SD_SHORT_CYC),
    .PB_ACTIVE_HIGH(PB_ACTIVE_HIGH)
) i_pbc_ctrl_chk (.clk(clk), .arst_n(arst_n),
    .pushbutton_input(pushbutton_input), .force_off_input(force_off_input),
    .latched_out(latched_out), .int_out(int_out), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

// [pbc_ctrl_tb.sv]
// self-checking bench of the pushbutton on/off controller
`timescale 1ns/1ps
module pbc_ctrl_tb;
    localparam int DB = 20;
    localparam int INTW = 5;
    localparam int SD = 100;
    logic clk;
    logic arst_n;
    logic pin;
    logic force_off;
    logic latched_out;
    logic int_out;
    logic irq;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    int n_mismatch;
    int n_tests;
    // ==========================================================
    // design, switch and clock
    // ==========================================================
    // short counts keep the run brief; expectations use DB, INTW, SD
    // only the selected options are shortened; the others stay unused
    pbc_ctrl #(.DB_SHORT_CYC(32'(DB)), .INT_8_CYC(32'(INTW)),
        .SD_SHORT_CYC(32'(SD))
    ) i_pbc_ctrl (.clk(clk), .arst_n(arst_n), .pushbutton_input(pin),
        .force_off_input(force_off), .latched_out(latched_out),
        .int_out(int_out), .irq(irq), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    pbc_button_model i_pbc_button_model (.clk(clk), .pin(pin));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================================
    // compare and bus tasks
    // ==========================================================
    task automatic chk1(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1
    task automatic chk32(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk32
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    // data stand only in the cycle after the strobe
    task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk32($sformatf("reg %h", a), exp, reg_rdata);
    endtask : check_reg
    // wait for a pulse, bounded, and compare its width
    task automatic measure_int(input int exp_w);
        int t;
        int w;
        t = 0;
        w = 0;
        while (int_out !== 1'b1 && t < 400) begin
            @(posedge clk);
            #1 t++;
        end
        while (int_out === 1'b1 && w < 400) begin
            @(posedge clk);
            #1 w++;
        end
        chk32("int_width", 32'(exp_w), 32'(w));
    endtask : measure_int
    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_reset;
        chk1("latched_out", 1'b0, latched_out);
        chk1("int_out", 1'b0, int_out);
        check_reg(8'h00, 32'h0);
        check_reg(8'h04, 32'h0);
        check_reg(8'h08, 32'h0);
        check_reg(8'h10, 32'h0);
        check_reg(8'h0c, 32'h10);
        reg_write(8'h08, 32'h7);
        check_reg(8'h08, 32'h7);
    endtask : t_reset
    task automatic t_chatter;
        i_pbc_button_model.chatter(4, DB / 2);
        repeat (DB) @(posedge clk);
        #1 chk1("latched_out", 1'b0, latched_out);
        chk1("int_out", 1'b0, int_out);
        check_reg(8'h04, 32'h0);
    endtask : t_chatter
    task automatic t_valid;
        fork
            i_pbc_button_model.press(DB * 3);
            measure_int(INTW);
        join
        @(posedge clk);
        #1 chk1("latched_out", 1'b1, latched_out);
        chk1("irq", 1'b1, irq);
        check_reg(8'h04, 32'h1);
        reg_write(8'h04, 32'h1);
        check_reg(8'h04, 32'h0);
        chk1("irq", 1'b0, irq);
    endtask : t_valid
    task automatic t_force;
        @(posedge clk);
        force_off <= 1'b1;
        #1 chk1("latched_out", 1'b0, latched_out);
        repeat (5) @(posedge clk);
        force_off <= 1'b0;
        @(posedge clk);
        #1 chk1("latched_out", 1'b0, latched_out);
        check_reg(8'h04, 32'h4);
        chk1("irq", 1'b1, irq);
        reg_write(8'h04, 32'h4);
        #1 chk1("irq", 1'b0, irq);
    endtask : t_force
    task automatic t_shutdown;
        fork
            i_pbc_button_model.press(SD + 30);
            begin
                measure_int(INTW);
                chk1("latched_out", 1'b1, latched_out);
                measure_int(INTW * 4);
            end
        join
        @(posedge clk);
        #1 chk1("latched_out", 1'b0, latched_out);
        check_reg(8'h04, 32'h3);
    endtask : t_shutdown
    // ==========================================================
    // main sequence, watchdog and verdict
    // ==========================================================
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        arst_n = 1'b0;
        force_off = 1'b0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_chatter();
        t_valid();
        t_force();
        t_shutdown();
        give_verdict();
    end
    // the whole run needs well under 1000 cycles
    initial begin
        #50us;
        n_mismatch++;
        $display("MISMATCH watchdog expected finish seen hang");
        give_verdict();
    end
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
endmodule : pbc_ctrl_tb

// [pbc_pkg.sv]
// shared constants of the pushbutton on/off controller
package pbc_pkg;
    // ==========================================================
    // clock and timing
    // ==========================================================
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    // debounce options, in ms
    localparam int unsigned T_DB_SHORT_MS = 50;
    localparam int unsigned T_DB_LONG_MS = 2000;
    // interrupt pulse options, in ms
    localparam int unsigned T_INT_8_MS = 8;
    localparam int unsigned T_INT_32_MS = 32;
    localparam int unsigned T_INT_64_MS = 64;
    localparam int unsigned T_INT_128_MS = 128;
    // shutdown options, in ms
    localparam int unsigned T_SD_SHORT_MS = 8000;
    localparam int unsigned T_SD_LONG_MS = 16000;
    // the long pulse is this many normal pulses
    localparam int unsigned LONG_INT_MULT = 4;
    // derived cycle counts (all exact multiples of the period)
    localparam logic [31:0] DB_SHORT_CYC = 32'(T_DB_SHORT_MS * CYC_PER_MS);
    localparam logic [31:0] DB_LONG_CYC = 32'(T_DB_LONG_MS * CYC_PER_MS);
    localparam logic [31:0] INT_8_CYC = 32'(T_INT_8_MS * CYC_PER_MS);
    localparam logic [31:0] INT_32_CYC = 32'(T_INT_32_MS * CYC_PER_MS);
    localparam logic [31:0] INT_64_CYC = 32'(T_INT_64_MS * CYC_PER_MS);
    localparam logic [31:0] INT_128_CYC = 32'(T_INT_128_MS * CYC_PER_MS);
    localparam logic [31:0] SD_SHORT_CYC = 32'(T_SD_SHORT_MS * CYC_PER_MS);
    localparam logic [31:0] SD_LONG_CYC = 32'(T_SD_LONG_MS * CYC_PER_MS);

    // ==========================================================
    // register map
    // ==========================================================
    localparam int unsigned REG_AW = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_STATE = 8'h0c;
    // control bits
    localparam int unsigned CTRL_SOFT_OFF_BIT = 0;
    localparam int unsigned CTRL_SOFT_ON_BIT = 1;
    // event bits, shared by status and mask
    localparam int unsigned EV_CLOSURE_BIT = 0;
    localparam int unsigned EV_SHUTDOWN_BIT = 1;
    localparam int unsigned EV_FORCE_OFF_BIT = 2;
    localparam int unsigned EV_W = 3;
    // state bits
    localparam int unsigned ST_OUT_BIT = 0;
    localparam int unsigned ST_INT_BIT = 1;
    localparam int unsigned ST_PRESSED_BIT = 2;
    localparam int unsigned ST_FSM_LSB = 4;
    // reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [2:0] EV_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
endpackage : pbc_pkg

// [pbc_pulse_tmr.sv]
// one-shot pulse timer, retriggerable with a new length
`timescale 1ns/1ps
module pbc_pulse_tmr (
    input wire logic clk,
    input wire logic arst_n,
    pbc_tmr_if.tmr t
);
    logic [31:0] left_q;

    // ==========================================================
    // countdown
    // ==========================================================
    // a new start reloads, so a long pulse can stretch a short one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            left_q <= 32'h0;
        end else if (t.start) begin
            left_q <= t.len;
        end else if (left_q != 32'h0) begin
            left_q <= left_q - 32'h1;
        end
    end

    assign t.busy = (left_q != 32'h0);
endmodule : pbc_pulse_tmr

// [pbc_tmr_if.sv]
// control link between the controller and its pulse timer
`timescale 1ns/1ps
interface pbc_tmr_if;
    logic start;
    logic [31:0] len;
    logic busy;
    modport ctl (output start, output len, input busy);
    modport tmr (input start, input len, output busy);
endinterface : pbc_tmr_if
